// ### design/p3ms_top.sv
// port 3 pins 0 to 4 function select registers and pad multiplexing
//
// How it works
// [RULE1] pin 4 two-bit field: input/timer d0 clock, pattern 4, lcd, output
// [RULE2] pin 3 field: input/capture, pattern 3, lcd, output, timer d0 out/pwm
// [RULE3] pin 2 field: input, pattern 2, lcd, output, timer c1 out/pwm
// [RULE4] low-byte register at EDh implements bits 5..0 only, reset zero
// [RULE5] pin 1 field: input, pattern 1, lcd, output, timer c0 out/pwm
// [RULE6] pin 0 field: input, pattern 0, lcd, output, timer b pwm
// [RULE7] pull-up enable register at EEh, one bit per pin, reset zero
// [RULE8] pull-up forced off for push-pull output or any alternate function
// [RULE9] software uses direct register addressing only for these registers
// [RULE10] middle-byte register at ECh, read-write, resets to zero
// [RULE11] output type register at EFh picks push-pull or open-drain (here the lcd source ignores it and keeps driving high levels)
// [RULE12] pad drive comes from the selected source; input releases the pad
`timescale 1ns/1ps
`include "p3ms_params.svh"
module p3ms_top
	import p3ms_pkg::*;
#(
	parameter int PINS = 5
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [PINS-1:0] gpio_data,
	input wire logic pattern_bit4,
	input wire logic pattern_bit3,
	input wire logic pattern_bit2,
	input wire logic pattern_bit1,
	input wire logic pattern_bit0,
	input wire logic lcd_segment_24,
	input wire logic lcd_segment_23,
	input wire logic lcd_segment_22,
	input wire logic lcd_segment_21,
	input wire logic lcd_segment_20,
	input wire logic timer_d0_output,
	input wire logic timer_d0_pwm_output,
	input wire logic timer_d0_pwm_select,
	input wire logic timer_c1_output,
	input wire logic timer_c1_pwm_output,
	input wire logic timer_c1_pwm_select,
	input wire logic timer_c0_output,
	input wire logic timer_c0_pwm_output,
	input wire logic timer_c0_pwm_select,
	input wire logic timer_b_pwm_output,
	input wire logic [PINS-1:0] pad_in,
	output logic [PINS-1:0] pad_out,
	output logic [PINS-1:0] pad_oe,
	output logic [PINS-1:0] pad_pullup,
	output logic [PINS-1:0] port_input_data,
	output logic timer_d0_clock_input,
	output logic timer_d0_capture_input
);
	logic [7:0] port3_middle_mode_select;
	logic [5:0] port3_low_mode_select;
	logic [7:0] port3_pullup_enable;
	logic [7:0] port3_output_type_select;
	logic [2:0] mode_field [PINS];
	logic [PINS-1:0] pattern_data;
	logic [PINS-1:0] lcd_data;
	logic [PINS-1:0] timer_data;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// the core only reaches these by direct register addressing, so a plain address port suffices [RULE9]
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			port3_middle_mode_select <= `P3MS_RESET_MIDDLE; // [RULE10]
		end else if (reg_write && reg_addr == `P3MS_ADDR_MIDDLE) begin
			port3_middle_mode_select <= reg_wdata; // [RULE10]
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			port3_low_mode_select <= `P3MS_RESET_LOW; // [RULE4]
		end else if (reg_write && reg_addr == `P3MS_ADDR_LOW) begin
			port3_low_mode_select <= reg_wdata[5:0]; // [RULE4]
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			port3_pullup_enable <= `P3MS_RESET_PULLUP; // [RULE7]
		end else if (reg_write && reg_addr == `P3MS_ADDR_PULLUP) begin
			port3_pullup_enable <= reg_wdata; // [RULE7]
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			port3_output_type_select <= `P3MS_RESET_OTYPE; // [RULE11]
		end else if (reg_write && reg_addr == `P3MS_ADDR_OTYPE) begin
			port3_output_type_select <= reg_wdata; // [RULE11]
		end
	end

	// unimplemented bits read as zero
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else begin
			case (reg_addr)
				`P3MS_ADDR_MIDDLE: reg_rdata <= port3_middle_mode_select;
				`P3MS_ADDR_LOW: reg_rdata <= {2'h0, port3_low_mode_select}; // [RULE4]
				`P3MS_ADDR_PULLUP: reg_rdata <= port3_pullup_enable;
				`P3MS_ADDR_OTYPE: reg_rdata <= port3_output_type_select;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// field extraction and source wiring
	// ----------------------------------------
	// pin 4 field is two bits and never reaches the timer code [RULE1]
	assign mode_field[4] = {1'b0, port3_middle_mode_select[`P3MS_PIN4_MSB:`P3MS_PIN4_LSB]}; // [RULE1]
	assign mode_field[3] = port3_middle_mode_select[`P3MS_PIN3_MSB:`P3MS_PIN3_LSB]; // [RULE2]
	assign mode_field[2] = port3_middle_mode_select[`P3MS_PIN2_MSB:`P3MS_PIN2_LSB]; // [RULE3]
	assign mode_field[1] = port3_low_mode_select[`P3MS_PIN1_MSB:`P3MS_PIN1_LSB]; // [RULE5]
	assign mode_field[0] = port3_low_mode_select[`P3MS_PIN0_MSB:`P3MS_PIN0_LSB]; // [RULE6]

	assign pattern_data = {pattern_bit4, pattern_bit3, pattern_bit2, pattern_bit1, pattern_bit0};
	assign lcd_data = {lcd_segment_24, lcd_segment_23, lcd_segment_22, lcd_segment_21, lcd_segment_20};
	assign timer_data[4] = 1'b0;
	assign timer_data[3] = timer_d0_pwm_select ? timer_d0_pwm_output : timer_d0_output; // [RULE2]
	assign timer_data[2] = timer_c1_pwm_select ? timer_c1_pwm_output : timer_c1_output; // [RULE3]
	assign timer_data[1] = timer_c0_pwm_select ? timer_c0_pwm_output : timer_c0_output; // [RULE5]
	assign timer_data[0] = timer_b_pwm_output; // [RULE6]

	// ----------------------------------------
	// pads
	// ----------------------------------------
	for (genvar i = 0; i < PINS; i++) begin : g_pin
		p3ms_pin_mux u_mux (
			.clock(clock),
			.rst_n(rst_n),
			.mode_field(mode_field[i]),
			.pullup_bit(port3_pullup_enable[i]),
			.open_drain(port3_output_type_select[i]),
			.gpio_data(gpio_data[i]),
			.pattern_data(pattern_data[i]),
			.lcd_data(lcd_data[i]),
			.timer_data(timer_data[i]),
			.pad_out(pad_out[i]),
			.pad_oe(pad_oe[i]),
			.pad_pullup(pad_pullup[i])
		);
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			port_input_data <= '0;
			timer_d0_clock_input <= 1'b0;
			timer_d0_capture_input <= 1'b0;
		end else begin
			port_input_data <= pad_in;
			// timer inputs gated so a driven pin cannot clock the timer
			timer_d0_clock_input <= (mode_field[4] == 3'h0) & pad_in[4]; // [RULE1]
			timer_d0_capture_input <= (mode_field[3] == 3'h0) & pad_in[3]; // [RULE2]
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_low_top_zero: assert property (@(posedge clock) disable iff (!rst_n) // [RULE4]
		(reg_addr == `P3MS_ADDR_LOW) |=> (reg_rdata[7:6] == 2'h0)) else $error("low register top bits not zero");
	a_middle_write: assert property (@(posedge clock) disable iff (!rst_n) // [RULE10]
		(reg_write && reg_addr == `P3MS_ADDR_MIDDLE) |=> (port3_middle_mode_select == $past(reg_wdata)))
		else $error("middle register write lost");
	a_pin3_timer: assert property (@(posedge clock) disable iff (!rst_n) // [RULE2]
		(mode_field[3][2] && !port3_output_type_select[3]) |=> (pad_oe[3] && pad_out[3] == $past(timer_data[3])))
		else $error("pin 3 timer output wrong");
	a_pin0_timer: assert property (@(posedge clock) disable iff (!rst_n) // [RULE6]
		(mode_field[0][2] && !port3_output_type_select[0]) |=> (pad_out[0] == $past(timer_b_pwm_output)))
		else $error("pin 0 pwm output wrong");
	a_pin4_gpio: assert property (@(posedge clock) disable iff (!rst_n) // [RULE1]
		(mode_field[4] == 3'h3 && !port3_output_type_select[4]) |=> (pad_oe[4] && pad_out[4] == $past(gpio_data[4])))
		else $error("pin 4 output wrong");
	a_pin2_pattern: assert property (@(posedge clock) disable iff (!rst_n) // [RULE3]
		(mode_field[2] == 3'h1 && !port3_output_type_select[2]) |=> (pad_out[2] == $past(pattern_bit2)))
		else $error("pin 2 pattern output wrong");
	a_pin1_lcd: assert property (@(posedge clock) disable iff (!rst_n) // [RULE5]
		(mode_field[1] == 3'h2) |=> (pad_oe[1] && pad_out[1] == $past(lcd_segment_21)))
		else $error("pin 1 lcd output wrong");
	a_capture_gate: assert property (@(posedge clock) disable iff (!rst_n) // [RULE2]
		(mode_field[3] != 3'h0) |=> !timer_d0_capture_input) else $error("capture not gated");
	a_low_write: assert property (@(posedge clock) disable iff (!rst_n) // [RULE4]
		(reg_write && reg_addr == `P3MS_ADDR_LOW) |=> (port3_low_mode_select == $past(reg_wdata[5:0])))
		else $error("low register write lost");
	a_pullup_write: assert property (@(posedge clock) disable iff (!rst_n) // [RULE7]
		(reg_write && reg_addr == `P3MS_ADDR_PULLUP) |=> (port3_pullup_enable == $past(reg_wdata)))
		else $error("pull-up register write lost");
	a_otype_write: assert property (@(posedge clock) disable iff (!rst_n) // [RULE11]
		(reg_write && reg_addr == `P3MS_ADDR_OTYPE) |=> (port3_output_type_select == $past(reg_wdata)))
		else $error("output type register write lost");
	a_middle_read: assert property (@(posedge clock) disable iff (!rst_n) // [RULE10]
		(reg_addr == `P3MS_ADDR_MIDDLE) |=> (reg_rdata == $past(port3_middle_mode_select)))
		else $error("middle register read wrong");
	a_pin4_lcd: assert property (@(posedge clock) disable iff (!rst_n) // [RULE1]
		(mode_field[4] == 3'h2) |=> (pad_oe[4] && pad_out[4] == $past(lcd_segment_24)))
		else $error("pin 4 lcd output wrong");
	a_clock_gate: assert property (@(posedge clock) disable iff (!rst_n) // [RULE1]
		(mode_field[4] != 3'h0) |=> !timer_d0_clock_input)
		else $error("timer clock input not gated");
	a_clock_follows: assert property (@(posedge clock) disable iff (!rst_n) // [RULE1]
		(mode_field[4] == 3'h0) |=> (timer_d0_clock_input == $past(pad_in[4])))
		else $error("timer clock input does not follow pin");
	a_pin2_timer: assert property (@(posedge clock) disable iff (!rst_n) // [RULE3]
		(mode_field[2][2] && !port3_output_type_select[2]) |=> (pad_oe[2] && pad_out[2] == $past(timer_data[2])))
		else $error("pin 2 timer output wrong");
	a_pin1_timer: assert property (@(posedge clock) disable iff (!rst_n) // [RULE5]
		(mode_field[1][2] && !port3_output_type_select[1]) |=> (pad_oe[1] && pad_out[1] == $past(timer_data[1])))
		else $error("pin 1 timer output wrong");
	a_pin0_pattern: assert property (@(posedge clock) disable iff (!rst_n) // [RULE6]
		(mode_field[0] == 3'h1 && !port3_output_type_select[0]) |=> (pad_out[0] == $past(pattern_bit0)))
		else $error("pin 0 pattern output wrong");
	a_drain_release: assert property (@(posedge clock) disable iff (!rst_n) // [RULE11]
		(port3_output_type_select[2] && mode_field[2] == 3'h3 && gpio_data[2]) |=> !pad_oe[2])
		else $error("open drain high not released");
endmodule : p3ms_top

// ### design/p3ms_params.svh
// register offsets, field positions and reset values for the port 3 pin function select block
`ifndef P3MS_PARAMS_SVH
`define P3MS_PARAMS_SVH
`define P3MS_ADDR_MIDDLE 8'hEC
`define P3MS_ADDR_LOW 8'hED
`define P3MS_ADDR_PULLUP 8'hEE
`define P3MS_ADDR_OTYPE 8'hEF
`define P3MS_RESET_MIDDLE 8'h00
`define P3MS_RESET_LOW 6'h00
`define P3MS_RESET_PULLUP 8'h00
`define P3MS_RESET_OTYPE 8'h00
`define P3MS_LOW_MASK 8'h3F
`define P3MS_PIN4_MSB 7
`define P3MS_PIN4_LSB 6
`define P3MS_PIN3_MSB 5
`define P3MS_PIN3_LSB 3
`define P3MS_PIN2_MSB 2
`define P3MS_PIN2_LSB 0
`define P3MS_PIN1_MSB 5
`define P3MS_PIN1_LSB 3
`define P3MS_PIN0_MSB 2
`define P3MS_PIN0_LSB 0
`endif

// ### design/p3ms_pkg.sv
// types shared by the port 3 pin function select block
package p3ms_pkg;
	typedef enum logic [4:0] {
		P3MS_SRC_INPUT = 5'h01,
		P3MS_SRC_PATTERN = 5'h02,
		P3MS_SRC_LCD = 5'h04,
		P3MS_SRC_GPIO = 5'h08,
		P3MS_SRC_TIMER = 5'h10
	} p3ms_src_type;

	// decode a three-bit mode field (pin 4's two bits arrive zero-extended) to a one-hot source
	function automatic p3ms_src_type p3ms_decode(input logic [2:0] field);
		p3ms_src_type src;
		src = P3MS_SRC_INPUT;
		case (field)
			3'h0: src = P3MS_SRC_INPUT;
			3'h1: src = P3MS_SRC_PATTERN;
			3'h2: src = P3MS_SRC_LCD;
			3'h3: src = P3MS_SRC_GPIO;
			default: src = P3MS_SRC_TIMER;
		endcase
		return src;
	endfunction : p3ms_decode
endpackage : p3ms_pkg

// ### design/p3ms_pin_mux.sv
// one pad's source multiplexer and pull-up control
`timescale 1ns/1ps
`include "p3ms_params.svh"
module p3ms_pin_mux
	import p3ms_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [2:0] mode_field,
	input wire logic pullup_bit,
	input wire logic open_drain,
	input wire logic gpio_data,
	input wire logic pattern_data,
	input wire logic lcd_data,
	input wire logic timer_data,
	output logic pad_out,
	output logic pad_oe,
	output logic pad_pullup
);
	p3ms_src_type src;
	logic next_out;
	logic next_oe;
	logic next_pullup;

	always_comb begin
		src = p3ms_decode(mode_field);
		next_out = 1'b0;
		next_oe = 1'b0;
		case (src)
			P3MS_SRC_INPUT: begin
				next_out = 1'b0;
				next_oe = 1'b0;
			end
			P3MS_SRC_PATTERN: begin
				next_out = pattern_data;
				next_oe = 1'b1;
			end
			P3MS_SRC_LCD: begin
				next_out = lcd_data;
				next_oe = 1'b1;
			end
			P3MS_SRC_GPIO: begin
				next_out = gpio_data;
				next_oe = 1'b1;
			end
			P3MS_SRC_TIMER: begin
				next_out = timer_data;
				next_oe = 1'b1;
			end
			default: begin
				next_out = 1'b0;
				next_oe = 1'b0;
			end
		endcase
		// open drain only sinks: a high level releases the pad, except on the lcd source, which keeps driving
		if (open_drain && next_oe && next_out && src != P3MS_SRC_LCD) begin
			next_oe = 1'b0;
		end
		// pull-up stays usable on input and on an open-drain plain output
		next_pullup = pullup_bit && (src == P3MS_SRC_INPUT || (src == P3MS_SRC_GPIO && open_drain));
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pad_out <= 1'b0;
			pad_oe <= 1'b0;
			pad_pullup <= 1'b0;
		end else begin
			pad_out <= next_out; // [RULE12]
			pad_oe <= next_oe; // [RULE12]
			pad_pullup <= next_pullup; // [RULE8] [RULE11]
		end
	end

	a_input_releases: assert property (@(posedge clock) disable iff (!rst_n)
		(mode_field == 3'h0) |=> !pad_oe) else $error("pad driven in input mode"); // [RULE12]
	a_pullup_forced_off: assert property (@(posedge clock) disable iff (!rst_n) // [RULE8]
		(mode_field != 3'h0 && !(mode_field == 3'h3 && open_drain)) |=> !pad_pullup)
		else $error("pull-up not forced off");
	a_pullup_follows: assert property (@(posedge clock) disable iff (!rst_n)
		(mode_field == 3'h0) |=> (pad_pullup == $past(pullup_bit))) else $error("pull-up ignores enable"); // [RULE7]
endmodule : p3ms_pin_mux

// ### test/p3ms_partner.sv
// far side model: pads, pattern generator, lcd drive and timer outputs
`timescale 1ns/1ps
module p3ms_partner (
	input wire logic clock,
	input wire logic lvl,
	input wire logic [4:0] pad_out,
	input wire logic [4:0] pad_oe,
	input wire logic [4:0] pad_pullup,
	output logic [4:0] pattern,
	output logic [4:0] lcd,
	output logic timer_out,
	output logic timer_pwm,
	output logic [4:0] pad_in
);
	// --------------------------------
	// pad level model
	// --------------------------------
	logic drift = 1'h0;
	// a released pad with no pull-up wanders, so it never holds a stale level
	always @(posedge clock) drift <= ~drift;
	assign pattern = {5{lvl}} ^ 5'h0A;
	assign lcd = ~pattern;
	assign timer_out = lvl;
	assign timer_pwm = ~lvl;
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & pad_pullup) | (~pad_oe & ~pad_pullup & {5{drift}});
endmodule : p3ms_partner

// ### test/tb_top.sv
// self-checking bench for the port 3 pin function select block
`timescale 1ns/1ps
`include "p3ms_params.svh"
module tb_top;
	import p3ms_pkg::*;
	// --------------------------------
	// stimulus and wiring
	// --------------------------------
	logic clock = 1'h0;
	logic rst_n = 1'h0;
	logic [7:0] reg_addr = 8'h00;
	logic reg_write = 1'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic [4:0] gpio_data = 5'h00;
	logic lvl = 1'h0;
	logic sel = 1'h0;
	logic [7:0] reg_rdata;
	logic [4:0] pad_in, pad_out, pad_oe, pad_pullup, port_input_data, pat, lcd;
	logic tmo, tmp, d0_clk, d0_cap;
	int n_errors = 0;
	int checks_done = 0;
	always #20 clock = ~clock;
	p3ms_partner u_far (.clock(clock), .lvl(lvl), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
		.pattern(pat), .lcd(lcd), .timer_out(tmo), .timer_pwm(tmp), .pad_in(pad_in));
	p3ms_top #(.PINS(5)) u_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_write(reg_write),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .gpio_data(gpio_data), .pattern_bit4(pat[4]),
		.pattern_bit3(pat[3]), .pattern_bit2(pat[2]), .pattern_bit1(pat[1]), .pattern_bit0(pat[0]),
		.lcd_segment_24(lcd[4]), .lcd_segment_23(lcd[3]), .lcd_segment_22(lcd[2]), .lcd_segment_21(lcd[1]),
		.lcd_segment_20(lcd[0]), .timer_d0_output(tmo), .timer_d0_pwm_output(tmp), .timer_d0_pwm_select(sel),
		.timer_c1_output(tmo), .timer_c1_pwm_output(tmp), .timer_c1_pwm_select(sel), .timer_c0_output(tmo),
		.timer_c0_pwm_output(tmp), .timer_c0_pwm_select(sel), .timer_b_pwm_output(tmp), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup), .port_input_data(port_input_data),
		.timer_d0_clock_input(d0_clk), .timer_d0_capture_input(d0_cap));
	// --------------------------------
	// shared tasks
	// --------------------------------
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		checks_done++;
		if (s !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, s);
			n_errors++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'h1;
		@(posedge clock);
		#1;
		reg_write = 1'h0;
		// idle edge so back-to-back writes never lower and raise the strobe in one step
		@(posedge clock);
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		reg_addr = a;
		@(posedge clock);
		#1;
		chk(nm, e, reg_rdata);
	endtask : rd
	task automatic finish_test;
		if (n_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	// --------------------------------
	// scenarios
	// --------------------------------
	task automatic t_regs;
		rd(`P3MS_ADDR_MIDDLE, 8'h00, "middle");
		rd(`P3MS_ADDR_LOW, 8'h00, "low");
		rd(`P3MS_ADDR_PULLUP, 8'h00, "pullup");
		rd(`P3MS_ADDR_OTYPE, 8'h00, "otype");
		wr(`P3MS_ADDR_LOW, 8'hFF);
		rd(`P3MS_ADDR_LOW, 8'h3F, "low");
		wr(8'hF0, 8'hFF);
		rd(8'hF0, 8'h00, "unmapped");
		wr(`P3MS_ADDR_OTYPE, 8'hA5);
		rd(`P3MS_ADDR_OTYPE, 8'hA5, "otype");
		wr(`P3MS_ADDR_MIDDLE, 8'hFF);
		rd(`P3MS_ADDR_MIDDLE, 8'hFF, "middle");
		wr(`P3MS_ADDR_PULLUP, 8'hFF);
		rd(`P3MS_ADDR_PULLUP, 8'hFF, "pullup");
		wr(`P3MS_ADDR_OTYPE, 8'h00);
	endtask : t_regs
	task automatic t_mode(input int m);
		logic [2:0] c;
		logic [4:0] ex;
		c = 3'(m);
		// pin 4 has no timer code, so it sits in output mode for that pass
		wr(`P3MS_ADDR_MIDDLE, {(m == 4) ? 2'h3 : c[1:0], c, c});
		wr(`P3MS_ADDR_LOW, {2'h0, c, c});
		for (int k = 0; k < 4; k++) begin
			lvl = k[0];
			sel = k[1];
			gpio_data = {5{k[0]}} ^ 5'h06;
			repeat (3) @(posedge clock);
			#1;
			case (m)
				0: ex = 5'h1F;
				1: ex = {5{lvl}} ^ 5'h0A;
				2: ex = ~({5{lvl}} ^ 5'h0A);
				3: ex = gpio_data;
				default: ex = {gpio_data[4], {3{sel ? ~lvl : lvl}}, ~lvl};
			endcase
			chk("pad_oe", {3'h0, (m == 0) ? 5'h00 : 5'h1F}, {3'h0, pad_oe});
			if (m != 0)
				chk("pad_out", {3'h0, ex}, {3'h0, pad_out});
			chk("pad_pullup", {3'h0, (m == 0) ? 5'h1F : 5'h00}, {3'h0, pad_pullup});
			chk("port_input_data", {3'h0, ex}, {3'h0, port_input_data});
			chk("timer_d0_inputs", (m == 0) ? 8'h03 : 8'h00, {6'h00, d0_clk, d0_cap});
		end
	endtask : t_mode
	task automatic t_drain;
		wr(`P3MS_ADDR_OTYPE, 8'h1F);
		wr(`P3MS_ADDR_MIDDLE, 8'hDB);
		wr(`P3MS_ADDR_LOW, 8'h1B);
		gpio_data = 5'h06;
		repeat (3) @(posedge clock);
		#1;
		chk("pad_oe", 8'h19, {3'h0, pad_oe});
		chk("pad_out", 8'h00, {3'h0, pad_out & pad_oe});
		chk("pad_pullup", 8'h1F, {3'h0, pad_pullup});
		chk("port_input_data", 8'h06, {3'h0, port_input_data});
	endtask : t_drain
	task automatic t_reset;
		rst_n = 1'h0;
		@(posedge clock);
		#1;
		rst_n = 1'h1;
		chk("pad_oe", 8'h00, {3'h0, pad_oe});
		rd(`P3MS_ADDR_MIDDLE, 8'h00, "middle");
		rd(`P3MS_ADDR_OTYPE, 8'h00, "otype");
	endtask : t_reset
	initial begin
		repeat (20000) @(posedge clock);
		n_errors++;
		finish_test();
	end
	initial begin
		repeat (3) @(posedge clock);
		#1;
		rst_n = 1'h1;
		t_regs();
		for (int m = 0; m < 5; m++)
			t_mode(m);
		t_drain();
		t_reset();
		finish_test();
	end
endmodule : tb_top
